//--- hw/ppmc_map.svh
`ifndef PPMC_MAP_SVH
`define PPMC_MAP_SVH
// Register indices (some printed offsets are not multiples of four)
`define PPMC_IDX_PA_DATA 12'h005
`define PPMC_IDX_PB_DATA 12'h006
`define PPMC_IDX_PA_MODE10 12'h085
`define PPMC_IDX_PA_MODE32 12'h086
`define PPMC_IDX_PA_MODE54 12'h087
`define PPMC_IDX_PA_MODE76 12'h088
`define PPMC_IDX_PB_MODE10 12'h08c
`define PPMC_IDX_PB_MODE2 12'h08d
`define PPMC_IDX_PB_MODE54 12'h08e
`define PPMC_IDX_PB_MODE6 12'h08f
`define PPMC_IDX_DRIVE_CFG 12'h105
`define PPMC_IDX_PC_FLAG 12'h00e
`define PPMC_IDX_SLEEP 12'h110
// Reset values
`define PPMC_RST_DATA 8'hff
`define PPMC_RST_MODE_PAIR 8'h11
`define PPMC_RST_MODE_SINGLE 8'h01
`define PPMC_RST_HIGH_SINK_SELECT 1'b1
// Field positions
`define PPMC_BIT_HIGH_SINK_SELECT 2
`define PPMC_BIT_UNDEF 5
`define PPMC_BIT_PCF 6
`define PPMC_PCF_CLEAR 8'hbf
`define PPMC_PA7 7
`endif

//--- hw/ppmc_pkg.sv
package ppmc_pkg;
    // Pin mode codes
    typedef enum logic [3:0] {
        PPMC_OD_PU = 4'h0, PPMC_OD = 4'h1, PPMC_PP = 4'h2, PPMC_ANALOG = 4'h3,
        PPMC_OD_B = 4'h4, PPMC_OD_C = 4'h5, PPMC_PP_B = 4'h6, PPMC_ALT = 4'h7,
        PPMC_WK_PU = 4'h8, PPMC_WK = 4'h9, PPMC_PP_C = 4'ha, PPMC_RSV_A = 4'hb,
        PPMC_WK_B = 4'hc, PPMC_WK_C = 4'hd, PPMC_PP_D = 4'he, PPMC_RSV_B = 4'hf
    } ppmc_mode_t;
    // Write channel progress
    typedef enum logic [2:0] {
        PPMC_WR_IDLE = 3'b001,
        PPMC_WR_RESP = 3'b010,
        PPMC_WR_HOLD = 3'b100
    } ppmc_wr_state_t;
    typedef logic [7:0] ppmc_byte_t;
endpackage : ppmc_pkg

//--- hw/ppmc_port_ctrl.sv
`timescale 1ns/100ps
`include "ppmc_map.svh"
// Functional notes
// - Codes 0,1,4,5 open-drain; 0 adds pull-up
// - Codes 2,6,A,E push-pull from data bit
// - Code 3 connects analog, digital off
// - Code 7 drives alternate function output on port A bits 0-6 only
// - Codes 8,9,C,D add pin-change wake-up
// - Port A bits 0-6 map PWM outputs
// - Analog channels 0-12 per pin table
// - Port A bit 7 reads 0 in analog
// - Port A modes paired at 85h-88h
// - Port B modes at 8Ch-8Fh, gaps unimplemented
// - Data registers 05h, 06h; reads give pins
// - High sink bit, never for port A bit 7
// - Drive config bit 5 read-only undefined
// - Enabled pin change wakes and flags
// - Pin-change detection armed only in sleep
// - Each pin has 4-bit mode field
// - Flag set on edge, cleared by BFh
module ppmc_port_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe_n,
    output logic [15:0] pin_pullup_en,
    output logic [15:0] pin_high_sink,
    output logic [12:0] converter_channel_input,
    input wire logic pwm_ch0_positive_out,
    input wire logic pwm_ch0_negative_out,
    input wire logic pwm_ch1_out,
    input wire logic pwm_ch2_out,
    input wire logic pwm_ch3_out,
    input wire logic pwm_ch4_out,
    input wire logic pwm_ch5_out,
    input wire logic sleep_entered,
    output logic pin_change_flag,
    output logic wake_up
);
    import ppmc_pkg::*;

    // ****************************************
    // Register storage
    // ****************************************
    ppmc_byte_t port_a_data_r;
    ppmc_byte_t port_b_data_r;
    logic [3:0] mode_r [16];
    logic high_sink_select_r;
    logic [1:0] drive_rsv_r;
    logic undef_bit_r;
    logic armed_r;
    logic pin_change_flag_r;

    // ****************************************
    // Bus slave
    // ****************************************
    ppmc_wr_state_t wr_state_r;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] aw_idx_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;
    logic wr_fire;
    logic [11:0] rd_idx;
    logic [15:0] pin_s1_r;
    logic [15:0] pin_s2_r;
    logic [15:0] pin_prev_r;
    logic [15:0] read_pins;
    logic [7:0] rd_byte;
    logic rd_ok;

    // Address and data may come in either order
    assign wr_fire = aw_held_r && w_held_r && (wr_state_r == PPMC_WR_IDLE);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_idx_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb0_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && (wr_state_r == PPMC_WR_IDLE);
            s_axi_wready <= !w_held_r && !s_axi_wready && (wr_state_r == PPMC_WR_IDLE);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr[13:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= PPMC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            case (wr_state_r)
                PPMC_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_r <= PPMC_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_known(aw_idx_r) ? 2'b00 : 2'b10;
                    end
                end
                PPMC_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_r <= PPMC_WR_HOLD;
                    end
                end
                PPMC_WR_HOLD: begin
                    wr_state_r <= PPMC_WR_IDLE;
                end
                default: begin
                    wr_state_r <= PPMC_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // Decode of mapped indices for the write response; the read channel decodes separately
    function automatic logic wr_known(input logic [11:0] idx);
        case (idx)
            `PPMC_IDX_PA_DATA, `PPMC_IDX_PB_DATA, `PPMC_IDX_PA_MODE10,
            `PPMC_IDX_PA_MODE32, `PPMC_IDX_PA_MODE54, `PPMC_IDX_PA_MODE76,
            `PPMC_IDX_PB_MODE10, `PPMC_IDX_PB_MODE2, `PPMC_IDX_PB_MODE54,
            `PPMC_IDX_PB_MODE6, `PPMC_IDX_DRIVE_CFG, `PPMC_IDX_PC_FLAG,
            `PPMC_IDX_SLEEP: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    endfunction : wr_known

    // ****************************************
    // Register writes
    // ****************************************
    // Only byte lane 0 carries the 8-bit registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_data_r <= `PPMC_RST_DATA;
            port_b_data_r <= `PPMC_RST_DATA;
            high_sink_select_r <= `PPMC_RST_HIGH_SINK_SELECT;
            drive_rsv_r <= 2'b00;
            for (int i = 0; i < 16; i++) begin
                mode_r[i] <= (i == 7 || i == 11 || i == 15) ? 4'h0 : 4'h1;
            end
        end else if (wr_fire && wstrb0_r) begin
            case (aw_idx_r)
                `PPMC_IDX_PA_DATA: port_a_data_r <= wdata_r[7:0];
                `PPMC_IDX_PB_DATA: port_b_data_r <= wdata_r[7:0];
                `PPMC_IDX_PA_MODE10: {mode_r[1], mode_r[0]} <= wdata_r[7:0];
                `PPMC_IDX_PA_MODE32: {mode_r[3], mode_r[2]} <= wdata_r[7:0];
                `PPMC_IDX_PA_MODE54: {mode_r[5], mode_r[4]} <= wdata_r[7:0];
                `PPMC_IDX_PA_MODE76: {mode_r[7], mode_r[6]} <= wdata_r[7:0];
                // port B, missing pins stay zero
                `PPMC_IDX_PB_MODE10: {mode_r[9], mode_r[8]} <= wdata_r[7:0];
                `PPMC_IDX_PB_MODE2: mode_r[10] <= wdata_r[3:0];
                `PPMC_IDX_PB_MODE54: {mode_r[13], mode_r[12]} <= wdata_r[7:0];
                `PPMC_IDX_PB_MODE6: mode_r[14] <= wdata_r[3:0];
                `PPMC_IDX_DRIVE_CFG: begin
                    high_sink_select_r <= wdata_r[`PPMC_BIT_HIGH_SINK_SELECT];
                    drive_rsv_r <= wdata_r[1:0];
                end
                default: ;
            endcase
        end
    end

    // bit 5 follows synchronised pin 0 each cycle, not writable; no reset
    always_ff @(posedge aclk) begin
        undef_bit_r <= pin_s2_r[0];
    end

    // ****************************************
    // Pin synchronisers and change detect
    // ****************************************
    always_ff @(posedge aclk) begin
        // No reset: chain tracks the pads in reset, so no false edge after it
        pin_s1_r <= pin_in;
        pin_s2_r <= pin_s1_r;
        pin_prev_r <= pin_s2_r;
    end

    logic [15:0] wake_en;
    logic [15:0] pin_edge;
    logic pc_clear;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_wake
            assign wake_en[g] = (mode_r[g] == 4'h8) || (mode_r[g] == 4'h9) ||
                                (mode_r[g] == 4'hc) || (mode_r[g] == 4'hd);
            assign pin_edge[g] = wake_en[g] && (pin_s2_r[g] != pin_prev_r[g]);
        end
    endgenerate
    assign pc_clear = wr_fire && wstrb0_r && (aw_idx_r == `PPMC_IDX_PC_FLAG) &&
                      (wdata_r[7:0] == `PPMC_PCF_CLEAR);

    // Arming: edges before sleep are not seen, as in the real part
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_r <= 1'b0;
        end else if (sleep_entered) begin
            armed_r <= 1'b1;
        end else if (pin_change_flag_r) begin
            armed_r <= 1'b0;
        end
    end

    // Flag: a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_change_flag_r <= 1'b0;
            wake_up <= 1'b0;
        end else begin
            if (armed_r && |pin_edge) begin
                pin_change_flag_r <= 1'b1;
            end else if (pc_clear) begin
                pin_change_flag_r <= 1'b0;
            end
            wake_up <= armed_r && |pin_edge;
        end
    end
    assign pin_change_flag = pin_change_flag_r;

    // ****************************************
    // Pad drive, registered (lands next cycle)
    // ****************************************
    logic [15:0] data_all;
    logic [15:0] alt_val;
    assign data_all = {port_b_data_r, port_a_data_r};
    assign alt_val = {9'h000, pwm_ch0_negative_out, pwm_ch3_out, pwm_ch0_positive_out,
                      pwm_ch2_out, pwm_ch4_out, pwm_ch1_out, pwm_ch5_out};

    generate
        for (g = 0; g < 16; g++) begin : g_pad
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_out[g] <= 1'b0;
                    pin_oe_n[g] <= 1'b1;
                    pin_pullup_en[g] <= 1'b0;
                end else begin
                    case (mode_r[g])
                        4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd: begin
                            pin_out[g] <= 1'b0;
                            pin_oe_n[g] <= data_all[g];
                            pin_pullup_en[g] <= data_all[g] &&
                                                (mode_r[g] == 4'h0 || mode_r[g] == 4'h8);
                        end
                        4'h2, 4'h6, 4'ha, 4'he: begin
                            pin_out[g] <= data_all[g];
                            pin_oe_n[g] <= 1'b0;
                            pin_pullup_en[g] <= 1'b0;
                        end
                        // alternate output, only where a source exists
                        4'h7: begin
                            pin_out[g] <= alt_val[g];
                            pin_oe_n[g] <= (g > 6);
                            pin_pullup_en[g] <= 1'b0;
                        end
                        default: begin
                            pin_out[g] <= 1'b0;
                            pin_oe_n[g] <= 1'b1;
                            pin_pullup_en[g] <= 1'b0;
                        end
                    endcase
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_high_sink[g] <= 1'b0;
                end else begin
                    pin_high_sink[g] <= high_sink_select_r && (g != `PPMC_PA7);
                end
            end
        end
    endgenerate

    // Analog connects: port A 0-6, port B 0,1,2,4,5,6
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_channel_input <= 13'h0000;
        end else begin
            for (int c = 0; c < 7; c++) begin
                converter_channel_input[c] <= (mode_r[c] == 4'h3);
            end
            converter_channel_input[7] <= (mode_r[8] == 4'h3);
            converter_channel_input[8] <= (mode_r[9] == 4'h3);
            converter_channel_input[9] <= (mode_r[10] == 4'h3);
            converter_channel_input[10] <= (mode_r[12] == 4'h3);
            converter_channel_input[11] <= (mode_r[13] == 4'h3);
            converter_channel_input[12] <= (mode_r[14] == 4'h3);
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_comb begin
        read_pins = pin_s2_r;
        // bit 7 reads 0 in analog
        if (mode_r[`PPMC_PA7] == 4'h3) begin
            read_pins[`PPMC_PA7] = 1'b0;
        end
        // Absent port B bits read 0
        read_pins[11] = 1'b0;
        read_pins[15] = 1'b0;
    end

    assign rd_idx = s_axi_araddr[13:2];
    always_comb begin
        rd_ok = 1'b1;
        case (rd_idx)
            `PPMC_IDX_PA_DATA: rd_byte = read_pins[7:0];
            `PPMC_IDX_PB_DATA: rd_byte = read_pins[15:8];
            `PPMC_IDX_PA_MODE10: rd_byte = {mode_r[1], mode_r[0]};
            `PPMC_IDX_PA_MODE32: rd_byte = {mode_r[3], mode_r[2]};
            `PPMC_IDX_PA_MODE54: rd_byte = {mode_r[5], mode_r[4]};
            `PPMC_IDX_PA_MODE76: rd_byte = {mode_r[7], mode_r[6]};
            `PPMC_IDX_PB_MODE10: rd_byte = {mode_r[9], mode_r[8]};
            `PPMC_IDX_PB_MODE2: rd_byte = {4'h0, mode_r[10]};
            `PPMC_IDX_PB_MODE54: rd_byte = {mode_r[13], mode_r[12]};
            `PPMC_IDX_PB_MODE6: rd_byte = {4'h0, mode_r[14]};
            `PPMC_IDX_DRIVE_CFG: rd_byte = {2'b00, undef_bit_r, 2'b00, high_sink_select_r,
                                            drive_rsv_r};
            `PPMC_IDX_PC_FLAG: rd_byte = {1'b0, pin_change_flag_r, 6'h00};
            `PPMC_IDX_SLEEP: rd_byte = {7'h00, armed_r};
            default: begin
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                             (!s_axi_rvalid && !s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ppmc_port_ctrl

//--- verif/ppmc_sva.sv
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module ppmc_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] pin_pullup_en,
    input wire logic [15:0] pin_high_sink,
    input wire logic [12:0] converter_channel_input,
    input wire logic sleep_entered,
    input wire logic pin_change_flag,
    input wire logic wake_up
);
    logic slept_r;
    logic [15:0] fl;
    logic [12:0] ch_hiz;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Sleep seen since reset; a flag may only rise after it
    always_ff @(posedge aclk) begin
        if (!aresetn) slept_r <= 1'b0;
        else if (sleep_entered) slept_r <= 1'b1;
    end
    // Floating pads in converter channel order
    assign fl = pin_oe_n & ~pin_pullup_en;
    assign ch_hiz = {fl[14:12], fl[10:8], fl[6:0]};
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing after address taken");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed before taken");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    pa7_sink_a: assert property (pin_high_sink[7] == 1'b0)
        else $error("port a bit 7 given high sink");
    an_hiz_a: assert property ((converter_channel_input & ~ch_hiz) == 13'h0)
        else $error("converter channel closed on a driven or pulled pad");
    drv_nopull_a: assert property ((~pin_oe_n & pin_pullup_en) == 16'h0)
        else $error("pull-up left on while pad driven");
    wake_flag_a: assert property (wake_up |-> pin_change_flag)
        else $error("wake pulse without pin-change flag");
    wake_pulse_a: assert property (wake_up |=> !wake_up [*2])
        else $error("wake pulse longer than one cycle");
    sleep_arm_a: assert property ($rose(pin_change_flag) |-> slept_r)
        else $error("pin-change flag set before any sleep");
endmodule : ppmc_sva

//--- verif/ppmc_pad_model.sv
`timescale 1ns/100ps
// ****************
// External pads and PWM sources
// ****************
module ppmc_pad_model (
    input wire logic aclk,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] pin_pullup_en,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    input wire logic [6:0] pwm_val,
    output logic [15:0] pad,
    output logic pwm_ch0_positive_out,
    output logic pwm_ch0_negative_out,
    output logic pwm_ch1_out,
    output logic pwm_ch2_out,
    output logic pwm_ch3_out,
    output logic pwm_ch4_out,
    output logic pwm_ch5_out
);
    logic flt_r = 1'b0;
    // Floating pads wander so a stale level never passes for a real one
    always @(posedge aclk) begin
        flt_r <= ~flt_r;
    end
    // Device drive wins, then the weak external driver, then pull-up
    assign pad = (~pin_oe_n & pin_out)
        | (pin_oe_n & ((ext_en & ext_val) | (~ext_en & (pin_pullup_en | {16{flt_r}}))));
    // Alternate sources, levels set by the bench
    assign {pwm_ch5_out, pwm_ch4_out, pwm_ch3_out, pwm_ch2_out} = pwm_val[6:3];
    assign {pwm_ch1_out, pwm_ch0_negative_out, pwm_ch0_positive_out} = pwm_val[2:0];
endmodule : ppmc_pad_model

//--- verif/ppmc_port_ctrl_tb.sv
`timescale 1ns/100ps
`include "ppmc_map.svh"
// ****************
// Bench top
// ****************
module ppmc_port_ctrl_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, sleep_entered = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic [15:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_high_sink;
    logic [15:0] ext_en = 16'hffff, ext_val = 16'hffff;
    logic [12:0] converter_channel_input;
    logic [6:0] pwm_val = '0;
    logic pwm_ch0_positive_out, pwm_ch0_negative_out, pwm_ch1_out, pwm_ch2_out;
    logic pwm_ch3_out, pwm_ch4_out, pwm_ch5_out, pin_change_flag, wake_up;
    logic [7:0] rd_d;
    int fail_count = 0, cmp_count = 0;
    int amap [7] = '{6, 2, 5, 3, 0, 4, 1};
    always #10 aclk = ~aclk;
    ppmc_port_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
        .pin_pullup_en, .pin_high_sink, .converter_channel_input, .pwm_ch0_positive_out,
        .pwm_ch0_negative_out, .pwm_ch1_out, .pwm_ch2_out, .pwm_ch3_out, .pwm_ch4_out,
        .pwm_ch5_out, .sleep_entered, .pin_change_flag, .wake_up);
    ppmc_pad_model u_pads (.aclk, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_en, .ext_val,
        .pwm_val, .pad(pin_in), .pwm_ch0_positive_out, .pwm_ch0_negative_out, .pwm_ch1_out,
        .pwm_ch2_out, .pwm_ch3_out, .pwm_ch4_out, .pwm_ch5_out);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask : tick
    // Address and data offered together; response ready raised in the cycle the response rises, so it never waits
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic a = 0, w = 0;
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            a |= s_axi_awready;
            w |= s_axi_wready;
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!(a && w) && ++n < 50);
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid && ++n < 60);
        chk("bresp", 3'b100, {s_axi_bvalid, s_axi_bresp});
        s_axi_bready <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [11:0] idx);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready && ++n < 50);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid && ++n < 60);
        rd_d = s_axi_rdata[7:0];
        rd_r = s_axi_rresp;
        chk("rvalid", 1'b1, s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rc(input string nm, input logic [11:0] idx, input logic [7:0] m, e);
        rd(idx);
        chk(nm, {2'b00, e}, {rd_r, rd_d & m});
    endtask : rc
    task automatic t_regs();
        logic [11:0] ix [8] = '{12'h085, 12'h086, 12'h087, 12'h088,
            12'h08c, 12'h08d, 12'h08e, 12'h08f};
        logic [7:0] ev [8] = '{8'h11, 8'h11, 8'h11, 8'h01, 8'h11, 8'h01, 8'h11, 8'h01};
        for (int i = 0; i < 8; i++) rc("mode reset", ix[i], 8'hff, ev[i]);
        rc("port a pins", `PPMC_IDX_PA_DATA, 8'hff, 8'hff);
        rc("port b pins", `PPMC_IDX_PB_DATA, 8'h77, 8'h77);
        // Bit 5 masked: its reset level is undefined
        rc("drive cfg", `PPMC_IDX_DRIVE_CFG, 8'hdf, 8'h04);
        rd(12'h089);
        chk("unmapped resp", 2'b10, rd_r);
        wr(`PPMC_IDX_PB_MODE2, 8'hff);
        rc("absent nibble", `PPMC_IDX_PB_MODE2, 8'hff, 8'h0f);
        wr(`PPMC_IDX_PB_MODE2, 8'h01);
        wr(`PPMC_IDX_PA_DATA, 8'h00);
        rc("pa pins driven low", `PPMC_IDX_PA_DATA, 8'hff, 8'h00);
        wr(`PPMC_IDX_PA_DATA, 8'hff);
    endtask : t_regs
    // Every mode code on port a bit 1 with both data levels, reserved ones included
    task automatic t_modes();
        logic [3:0] c;
        logic od, pp, drv, pu;
        @(posedge aclk);
        pwm_val <= 7'h04;
        for (int i = 0; i < 32; i++) begin
            c = i[4:1];
            od = c inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd};
            pp = c inside {4'h2, 4'h6, 4'ha, 4'he};
            drv = pp || c == 4'h7 || (od && !i[0]);
            pu = (c == 4'h0 || c == 4'h8) && i[0];
            wr(`PPMC_IDX_PA_DATA, {6'h3f, i[0], 1'b1});
            wr(`PPMC_IDX_PA_MODE10, {c, 4'h1});
            chk("pa1 pad", {!drv, pu, drv & (pp ? i[0] : c == 4'h7), (c == 4'h3) ? 13'h2 : 13'h0},
                {pin_oe_n[1], pin_pullup_en[1], drv & pin_out[1], converter_channel_input});
        end
        wr(`PPMC_IDX_PA_DATA, 8'hff);
    endtask : t_modes
    task automatic t_alt();
        logic [6:0] e;
        for (int r = 0; r < 4; r++) wr(`PPMC_IDX_PA_MODE10 + r[11:0], 8'h77);
        for (int k = 0; k < 7; k++) begin
            @(posedge aclk);
            pwm_val <= 7'h01 << k;
            tick(2);
            for (int p = 0; p < 7; p++) e[p] = (amap[p] == k);
            chk("alt pads", {8'h80, 1'b0, e}, {pin_oe_n[7:0], 1'b0, pin_out[6:0]});
        end
        for (int r = 0; r < 3; r++) wr(`PPMC_IDX_PA_MODE10 + r[11:0], 8'h11);
    endtask : t_alt
    task automatic t_analog();
        wr(`PPMC_IDX_PA_MODE76, 8'h31);
        wr(`PPMC_IDX_PB_MODE10, 8'h31);
        chk("channels", 13'h0100, converter_channel_input);
        rc("pa7 analog read", `PPMC_IDX_PA_DATA, 8'hff, 8'h7f);
        wr(`PPMC_IDX_PA_MODE76, 8'h11);
        rc("pa7 digital read", `PPMC_IDX_PA_DATA, 8'hff, 8'hff);
        wr(`PPMC_IDX_PB_MODE10, 8'h11);
    endtask : t_analog
    // Low bits kept zero as software must
    task automatic t_sink();
        wr(`PPMC_IDX_DRIVE_CFG, 8'h00);
        chk("sink low", 16'h0000, pin_high_sink & 16'h77ff);
        wr(`PPMC_IDX_DRIVE_CFG, 8'h04);
        chk("sink high", 16'h777f, pin_high_sink & 16'h77ff);
    endtask : t_sink
    // Edges before sleep and on a plain input must not flag
    task automatic t_wake();
        int n = 0;
        wr(`PPMC_IDX_PA_MODE32, 8'h19);
        @(posedge aclk);
        ext_val[2] <= 1'b0;
        tick(6);
        rc("flag before sleep", `PPMC_IDX_PC_FLAG, 8'h40, 8'h00);
        @(posedge aclk);
        sleep_entered <= 1'b1;
        @(posedge aclk);
        sleep_entered <= 1'b0;
        ext_val[3] <= 1'b0;
        tick(6);
        chk("flag plain pin", 1'b0, pin_change_flag);
        @(posedge aclk);
        ext_val[2] <= 1'b1;
        do @(posedge aclk); while (!wake_up && ++n < 10);
        chk("wake pulse", 1'b1, wake_up);
        rc("flag set", `PPMC_IDX_PC_FLAG, 8'h40, 8'h40);
        wr(`PPMC_IDX_PC_FLAG, 8'hbf);
        rc("flag cleared", `PPMC_IDX_PC_FLAG, 8'h40, 8'h00);
    endtask : t_wake
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_alt();
        t_analog();
        t_sink();
        t_wake();
        end_sim();
    end
    // Run needs well under 1000 cycles; this cuts a hang at 10000 cycles, well beyond that
    initial begin
        #200000;
        chk("timeout", 1'b0, 1'b1);
        end_sim();
    end
endmodule : ppmc_port_ctrl_tb
bind ppmc_port_ctrl ppmc_sva u_sva (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .pin_oe_n,
    .pin_pullup_en, .pin_high_sink, .converter_channel_input, .sleep_entered,
    .pin_change_flag, .wake_up);
